// ---- src/isf_params.svh ----
`ifndef ISF_PARAMS_SVH
`define ISF_PARAMS_SVH

// register indices; byte address is four times the index
`define ISF_IDX_FLAGS      8'h01
`define ISF_IDX_STATUS     8'h02
`define ISF_IDX_LOCK_CTL   8'h37
// reset values
`define ISF_FLAGS_RST      6'h00
`define ISF_STATUS_RST     8'h00
`define ISF_LOCK_CTL_RST   1'b0
// flag bit positions
`define ISF_FLG_SECOND     5
`define ISF_FLG_FIRST      4
`define ISF_FLG_LOCK       3
`define ISF_FLG_OVERFLOW   2
`define ISF_FLG_INPUT      1
`define ISF_FLG_EVENT      0
`define ISF_NUM_FLAGS      6
// status bit positions
`define ISF_ST_SECOND      7
`define ISF_ST_FIRST       6
`define ISF_ST_LOCKED      5
`define ISF_ST_EC_MSB      4
// lock control bit position
`define ISF_LOCK_EN_BIT    0
// bus answers
`define ISF_RESP_OKAY      2'h0
`define ISF_RESP_SLVERR    2'h2
`endif

// ---- src/isf_pkg.sv ----
package isf_pkg;
   // register selected by an address
   typedef enum logic [1:0] {SEL_NONE, SEL_FLAGS, SEL_STATUS, SEL_LOCK} isf_sel_t;

   // one-cycle event pulses from the flag sources
   typedef struct packed {
      logic second_logic;
      logic first_logic;
      logic overflow;
      logic input_chg;
      logic input_is_fifo;
      logic key_chg;
      logic logic_fifo_evt;
   } isf_evt_t;

   // levels from the rest of the device
   typedef struct packed {
      logic       second_level;
      logic       first_level;
      logic       locked;
      logic [4:0] event_count;
      logic       any_pin_flag;
   } isf_stat_in_t;

   typedef struct packed {
      logic flag;
   } isf_flag_st_t;

   typedef struct packed {
      logic locked;
      logic mask;
      logic irq;
   } isf_lock_st_t;

   typedef struct packed {
      logic       awready;
      logic       wready;
      logic       arready;
      logic       aw_got;
      logic       w_got;
      isf_sel_t   wsel;
      logic [7:0] wdata;
      logic       wstrb0;
      logic       bvalid;
      logic [1:0] bresp;
      logic       rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic       lock_en;
      logic [7:0] status;
   } isf_top_st_t;
endpackage

// ---- src/isf_flag_bit.sv ----
`timescale 1ns/100ps
module isf_flag_bit (
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   // event, clear request and clear veto
   input  wire logic set_i,
   input  wire logic clr_i,
   input  wire logic hold_i,
   // sticky flag
   output logic      flag_o
);
   isf_pkg::isf_flag_st_t st_d;
   isf_pkg::isf_flag_st_t st_q;

   // set wins over a clear in the same cycle so no event is lost
   always_comb begin
      st_d = st_q;
      if (set_i) begin
         st_d.flag = 1'b1;
      end else if (clr_i && !hold_i) begin
         st_d.flag = 1'b0;
      end
   end

   // flag register
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign flag_o = st_q.flag;
endmodule

// ---- src/isf_lock_evt.sv ----
`timescale 1ns/100ps
module isf_lock_evt (
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   // lock state and software cause
   input  wire logic locked_i,
   input  wire logic sw_cause_i,
   // lock change pulse
   output logic      lock_irq_o
);
   isf_pkg::isf_lock_st_t st_d;
   isf_pkg::isf_lock_st_t st_q;
   logic                  chg;

   assign chg = locked_i != st_q.locked;

   // a software-caused change is absorbed by the armed mask; the mask
   // stays armed until the engine actually changes state
   always_comb begin
      st_d        = st_q;
      st_d.locked = locked_i;
      st_d.irq    = chg && !st_q.mask && !sw_cause_i;
      if (sw_cause_i) begin
         st_d.mask = !chg;
      end else if (chg) begin
         st_d.mask = 1'b0;
      end
   end

   // state register
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign lock_irq_o = st_q.irq;

   // a genuine lock change gives a pulse one cycle later
   AST_LOCK_PULSE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (chg && !st_q.mask && !sw_cause_i) |=> lock_irq_o)
      else $error("lock change gave no lock pulse");

   // a change that follows a software cause is silent
   AST_SW_LOCK_QUIET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (st_q.mask && chg) |=> !lock_irq_o)
      else $error("software lock change raised a pulse");
endmodule

// ---- src/isf_top.sv ----
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "isf_params.svh"
module isf_top (
   // clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_n_i,
   // axi4-lite write address
   input  wire logic [11:0]           s_axi_awaddr_i,
   input  wire logic [2:0]            s_axi_awprot_i,
   input  wire logic                  s_axi_awvalid_i,
   output logic                       s_axi_awready_o,
   // axi4-lite write data
   input  wire logic [31:0]           s_axi_wdata_i,
   input  wire logic [3:0]            s_axi_wstrb_i,
   input  wire logic                  s_axi_wvalid_i,
   output logic                       s_axi_wready_o,
   // axi4-lite write response
   output logic [1:0]                 s_axi_bresp_o,
   output logic                       s_axi_bvalid_o,
   input  wire logic                  s_axi_bready_i,
   // axi4-lite read address
   input  wire logic [11:0]           s_axi_araddr_i,
   input  wire logic [2:0]            s_axi_arprot_i,
   input  wire logic                  s_axi_arvalid_i,
   output logic                       s_axi_arready_o,
   // axi4-lite read data
   output logic [31:0]                s_axi_rdata_o,
   output logic [1:0]                 s_axi_rresp_o,
   output logic                       s_axi_rvalid_o,
   input  wire logic                  s_axi_rready_i,
   // flag sources and device levels
   input  wire isf_pkg::isf_evt_t     evt_i,
   input  wire isf_pkg::isf_stat_in_t stat_i,
   // to the lock engine and the interrupt pin logic
   output logic                       lock_en_o,
   output logic [7:0]                 irq_flags_o
);

   //--------------------------------------------------------------
   // address decode
   //--------------------------------------------------------------

   // only aligned words inside the index space are mapped
   function automatic isf_pkg::isf_sel_t isf_map(input logic [11:0] addr);
      logic [7:0] idx;
      idx = addr[9:2];
      if (addr[11:10] != 2'h0 || addr[1:0] != 2'h0) begin
         isf_map = isf_pkg::SEL_NONE;
      end else if (idx == `ISF_IDX_FLAGS) begin
         isf_map = isf_pkg::SEL_FLAGS;
      end else if (idx == `ISF_IDX_STATUS) begin
         isf_map = isf_pkg::SEL_STATUS;
      end else if (idx == `ISF_IDX_LOCK_CTL) begin
         isf_map = isf_pkg::SEL_LOCK;
      end else begin
         isf_map = isf_pkg::SEL_NONE;
      end
   endfunction

   //--------------------------------------------------------------
   // state
   //--------------------------------------------------------------

   isf_pkg::isf_top_st_t             st_d;
   isf_pkg::isf_top_st_t             st_q;
   logic                             do_wr;
   logic                             lock_wr;
   logic                             sw_cause;
   logic                             lock_irq;
   logic                             aw_take;
   logic                             w_take;
   logic                             ar_take;
   logic [`ISF_NUM_FLAGS-1:0]        set_vec;
   logic [`ISF_NUM_FLAGS-1:0]        clr_vec;
   logic [`ISF_NUM_FLAGS-1:0]        hold_vec;
   logic [`ISF_NUM_FLAGS-1:0]        flg;
   isf_pkg::isf_sel_t                rsel;

   // handshakes on the three request channels
   assign aw_take = s_axi_awvalid_i && st_q.awready;
   assign w_take  = s_axi_wvalid_i && st_q.wready;
   assign ar_take = s_axi_arvalid_i && st_q.arready;
   assign rsel    = isf_map(s_axi_araddr_i);

   // a write lands one cycle after both halves are held
   assign do_wr   = st_q.aw_got && st_q.w_got && !st_q.bvalid;
   assign lock_wr = do_wr && st_q.wsel == isf_pkg::SEL_LOCK && st_q.wstrb0;

   //--------------------------------------------------------------
   // flag sources
   //--------------------------------------------------------------

   // writing ones clears; bits 7 and 6 of the data are never used
   assign clr_vec = (do_wr && st_q.wsel == isf_pkg::SEL_FLAGS && st_q.wstrb0) ?
                    st_q.wdata[`ISF_NUM_FLAGS-1:0] : 6'h00;

   // only the general input flag can be vetoed
   always_comb begin
      hold_vec                 = 6'h00;
      hold_vec[`ISF_FLG_INPUT] = stat_i.any_pin_flag;
   end

   // software caused lock change: the write moves the state it asks for
   assign sw_cause = lock_wr &&
                     (st_q.wdata[`ISF_LOCK_EN_BIT] != st_q.lock_en) &&
                     (st_q.wdata[`ISF_LOCK_EN_BIT] != stat_i.locked);

   // event sources per flag bit
   always_comb begin
      set_vec                    = 6'h00;
      set_vec[`ISF_FLG_SECOND]   = evt_i.second_logic;
      set_vec[`ISF_FLG_FIRST]    = evt_i.first_logic;
      set_vec[`ISF_FLG_LOCK]     = lock_irq;
      set_vec[`ISF_FLG_OVERFLOW] = evt_i.overflow;
      set_vec[`ISF_FLG_INPUT]    = evt_i.input_chg && !evt_i.input_is_fifo;
      set_vec[`ISF_FLG_EVENT]    = evt_i.key_chg || evt_i.logic_fifo_evt ||
                                   (evt_i.input_chg && evt_i.input_is_fifo);
   end

   //--------------------------------------------------------------
   // sticky flags and lock change detection
   //--------------------------------------------------------------

   genvar gi;
   generate
      for (gi = 0; gi < `ISF_NUM_FLAGS; gi++) begin : g_flag
         isf_flag_bit u_flag (
            .sys_clk_i (sys_clk_i),
            .rst_n_i   (rst_n_i),
            .set_i     (set_vec[gi]),
            .clr_i     (clr_vec[gi]),
            .hold_i    (hold_vec[gi]),
            .flag_o    (flg[gi])
         );
      end
   endgenerate

   // lock engine changes become flag events unless software caused them
   isf_lock_evt u_lock (
      .sys_clk_i  (sys_clk_i),
      .rst_n_i    (rst_n_i),
      .locked_i   (stat_i.locked),
      .sw_cause_i (sw_cause),
      .lock_irq_o (lock_irq)
   );

   //--------------------------------------------------------------
   // bus slave and register file
   //--------------------------------------------------------------

   // next state of the slave, the lock control and the status copy
   always_comb begin
      st_d = st_q;
      // status is a registered copy of the device levels
      st_d.status[`ISF_ST_SECOND] = stat_i.second_level;
      st_d.status[`ISF_ST_FIRST]  = stat_i.first_level;
      st_d.status[`ISF_ST_LOCKED] = stat_i.locked;
      st_d.status[`ISF_ST_EC_MSB:0] = stat_i.event_count;
      // write address channel
      if (aw_take) begin
         st_d.aw_got  = 1'b1;
         st_d.awready = 1'b0;
         st_d.wsel    = isf_map(s_axi_awaddr_i);
      end
      // write data channel; only the low lane carries register bits
      if (w_take) begin
         st_d.w_got  = 1'b1;
         st_d.wready = 1'b0;
         st_d.wdata  = s_axi_wdata_i[7:0];
         st_d.wstrb0 = s_axi_wstrb_i[0];
      end
      // perform the write and raise the response
      if (do_wr) begin
         st_d.aw_got = 1'b0;
         st_d.w_got  = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp  = (st_q.wsel == isf_pkg::SEL_NONE) ? `ISF_RESP_SLVERR : `ISF_RESP_OKAY;
         if (lock_wr) begin
            st_d.lock_en = st_q.wdata[`ISF_LOCK_EN_BIT];
         end
      end
      // response taken: reopen both request channels
      if (st_q.bvalid && s_axi_bready_i) begin
         st_d.bvalid  = 1'b0;
         st_d.bresp   = `ISF_RESP_OKAY;
         st_d.awready = 1'b1;
         st_d.wready  = 1'b1;
      end
      // read address taken: data is captured in the same edge
      if (ar_take) begin
         st_d.arready = 1'b0;
         st_d.rvalid  = 1'b1;
         st_d.rresp   = `ISF_RESP_OKAY;
         unique case (rsel)
            isf_pkg::SEL_FLAGS: begin
               st_d.rdata = {2'h0, flg};
            end
            isf_pkg::SEL_STATUS: begin
               st_d.rdata = st_q.status;
            end
            isf_pkg::SEL_LOCK: begin
               st_d.rdata = {7'h00, st_q.lock_en};
            end
            isf_pkg::SEL_NONE: begin
               st_d.rdata = 8'h00;
               st_d.rresp = `ISF_RESP_SLVERR;
            end
         endcase
      end
      // read data taken
      if (st_q.rvalid && s_axi_rready_i) begin
         st_d.rvalid  = 1'b0;
         st_d.rdata   = 8'h00;
         st_d.rresp   = `ISF_RESP_OKAY;
         st_d.arready = 1'b1;
      end
      // readies come up at the first edge after reset
      if (!st_q.aw_got && !st_q.w_got && !st_q.bvalid && !st_q.awready &&
          !st_q.wready) begin
         st_d.awready = 1'b1;
         st_d.wready  = 1'b1;
      end
      if (!st_q.rvalid && !st_q.arready) begin
         st_d.arready = 1'b1;
      end
   end

   // one register for the whole slave state
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q         <= '0;
         st_q.lock_en <= `ISF_LOCK_CTL_RST;
         st_q.status  <= `ISF_STATUS_RST;
      end else begin
         st_q <= st_d;
      end
   end

   //--------------------------------------------------------------
   // outputs
   //--------------------------------------------------------------

   // all straight from the state register or the flag registers
   assign s_axi_awready_o = st_q.awready;
   assign s_axi_wready_o  = st_q.wready;
   assign s_axi_bvalid_o  = st_q.bvalid;
   assign s_axi_bresp_o   = st_q.bresp;
   assign s_axi_arready_o = st_q.arready;
   assign s_axi_rvalid_o  = st_q.rvalid;
   assign s_axi_rresp_o   = st_q.rresp;
   assign s_axi_rdata_o   = {24'h000000, st_q.rdata};
   assign lock_en_o       = st_q.lock_en;
   assign irq_flags_o     = {2'h0, flg};

   //--------------------------------------------------------------
   // checks
   //--------------------------------------------------------------

   // flag events
   AST_SECOND_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      evt_i.second_logic |=> flg[`ISF_FLG_SECOND])
      else $error("second logic event did not set its flag");

   AST_FIRST_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      evt_i.first_logic |=> flg[`ISF_FLG_FIRST])
      else $error("first logic event did not set its flag");

   // a flag falls only where a one was written the cycle before
   AST_W1C_ONLY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ##1 (($past(flg) & ~flg & ~$past(clr_vec)) == 6'h00))
      else $error("flag fell without a clearing write");

   // a written one clears the idle overflow flag one cycle after both halves are held
   sequence flags_wr_s;
      do_wr && st_q.wsel == isf_pkg::SEL_FLAGS && st_q.wstrb0;
   endsequence
   AST_W1C_CLEARS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (flags_wr_s and (st_q.wdata[`ISF_FLG_OVERFLOW] && !evt_i.overflow))
      |=> !flg[`ISF_FLG_OVERFLOW])
      else $error("overflow flag survived a clearing write");

   AST_LOCK_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      lock_irq |=> flg[`ISF_FLG_LOCK])
      else $error("lock change did not set the lock flag");

   AST_OVERFLOW_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      evt_i.overflow |=> flg[`ISF_FLG_OVERFLOW])
      else $error("overflow did not set its flag");

   AST_INPUT_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (evt_i.input_chg && !evt_i.input_is_fifo) |=> flg[`ISF_FLG_INPUT])
      else $error("input change did not set the input flag");

   AST_INPUT_FIFO_QUIET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (evt_i.input_chg && evt_i.input_is_fifo && !flg[`ISF_FLG_INPUT])
      |=> !flg[`ISF_FLG_INPUT])
      else $error("fifo recorded input set the input flag");

   AST_INPUT_CLR_HELD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (flg[`ISF_FLG_INPUT] && clr_vec[`ISF_FLG_INPUT] && stat_i.any_pin_flag)
      |=> flg[`ISF_FLG_INPUT])
      else $error("input flag cleared while a per-pin flag is set");

   AST_EVENT_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (evt_i.key_chg || evt_i.logic_fifo_evt || (evt_i.input_chg && evt_i.input_is_fifo))
      |=> flg[`ISF_FLG_EVENT])
      else $error("recorded event did not set the event flag");

   // status copy follows the device levels one cycle late
   AST_STATUS_TRACKS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ##1 (st_q.status == {$past(stat_i.second_level), $past(stat_i.first_level),
                           $past(stat_i.locked), $past(stat_i.event_count)}))
      else $error("status register does not follow the device levels");

   // reads of the flag register answer next cycle with zero upper bits
   sequence flags_rd_s;
      ar_take && rsel == isf_pkg::SEL_FLAGS;
   endsequence
   AST_RESERVED_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      flags_rd_s |=> (s_axi_rvalid_o && s_axi_rdata_o[31:6] == 26'h0000000 &&
                      s_axi_rdata_o[5:0] == $past(flg)))
      else $error("flag read returned wrong data or reserved bits");

   // bus answers
   sequence both_halves_s;
      st_q.aw_got && st_q.w_got && !st_q.bvalid;
   endsequence
   // the response rises on the edge after both halves are held
   AST_WR_ANSWER: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      both_halves_s |=> s_axi_bvalid_o)
      else $error("write response missing");

   // the response and its code stand until the master takes them
   AST_WR_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_axi_bvalid_o && !s_axi_bready_i) |=> (s_axi_bvalid_o && $stable(s_axi_bresp_o)))
      else $error("write response dropped before it was taken");

   // a taken read address is answered on the next cycle
   AST_RD_ANSWER: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ar_take |=> s_axi_rvalid_o)
      else $error("read answer missing");

   AST_RD_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_axi_rvalid_o && !s_axi_rready_i) |=> (s_axi_rvalid_o && $stable(s_axi_rdata_o)))
      else $error("read data changed before it was taken");

endmodule

// ---- dv/isf_host.sv ----
`timescale 1ns/100ps
module isf_host (
   // clock
   input  wire logic        sys_clk_i,
   // write request
   output logic [11:0]      awaddr_o,
   output logic             awvalid_o,
   output logic [31:0]      wdata_o,
   output logic [3:0]       wstrb_o,
   output logic             wvalid_o,
   output logic             bready_o,
   // read request
   output logic [11:0]      araddr_o,
   output logic             arvalid_o,
   output logic             rready_o,
   // slave answers
   input  wire logic        awready_i,
   input  wire logic        wready_i,
   input  wire logic        bvalid_i,
   input  wire logic [1:0]  bresp_i,
   input  wire logic        arready_i,
   input  wire logic        rvalid_i,
   input  wire logic [1:0]  rresp_i,
   input  wire logic [31:0] rdata_i
);
   // idle bus at time zero
   initial begin
      {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
      {araddr_o, arvalid_o, rready_o} = '0;
   end

   // ready is looked at just before the edge, so each channel drops at its own take edge
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ga, gw, ta, tw, tb;
      ga = 1'b0;
      gw = 1'b0;
      tb = 1'b0;
      @(posedge sys_clk_i);
      awaddr_o  <= a;
      wdata_o   <= d;
      wstrb_o   <= 4'hf;
      awvalid_o <= 1'b1;
      wvalid_o  <= 1'b1;
      bready_o  <= 1'b1;
      while (!tb) begin
         @(negedge sys_clk_i);
         ta = !ga && awready_i;
         tw = !gw && wready_i;
         tb = ga && gw && bvalid_i;
         r  = bresp_i;
         @(posedge sys_clk_i);
         if (ta) awvalid_o <= 1'b0;
         if (tw) wvalid_o <= 1'b0;
         if (tb) bready_o <= 1'b0;
         ga = ga | ta;
         gw = gw | tw;
      end
   endtask

   // rready stays up until the answer, which arrives after the address is taken
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ga, ta, tr;
      ga = 1'b0;
      tr = 1'b0;
      @(posedge sys_clk_i);
      araddr_o  <= a;
      arvalid_o <= 1'b1;
      rready_o  <= 1'b1;
      while (!tr) begin
         @(negedge sys_clk_i);
         ta = !ga && arready_i;
         tr = ga && rvalid_i;
         d  = rdata_i;
         r  = rresp_i;
         @(posedge sys_clk_i);
         if (ta) arvalid_o <= 1'b0;
         if (tr) rready_o <= 1'b0;
         ga = ga | ta;
      end
   endtask
endmodule

// ---- dv/interrupt_and_status_flags_tb.sv ----
`timescale 1ns/100ps
module interrupt_and_status_flags_tb;
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin miscompares++; \
   $display("[FAIL] %s exp %h got %h", n, e, s); end end
   logic                  clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic                  arvalid, arready, rvalid, rready, lock_en;
   logic [11:0]           awaddr, araddr;
   logic [31:0]           wdata, rdata, d, s;
   logic [3:0]            wstrb;
   logic [1:0]            bresp, rresp;
   logic [7:0]            irq_flags, m;
   logic [6:0]            e;
   isf_pkg::isf_evt_t     evt;
   isf_pkg::isf_stat_in_t stat;
   int                    miscompares, num_checks, cyc;

   // flag bits that one pulse vector must raise, fifo-recorded inputs going to bit 0
   function automatic logic [7:0] exp_flags(input logic [6:0] v);
      return {2'b00, v[6], v[5], 1'b0, v[4], v[3] & ~v[2], v[1] | v[0] | (v[3] & v[2])};
   endfunction
   // status is the level bundle without the per-pin flag
   function automatic logic [7:0] exp_status(input logic [8:0] v);
      return v[8:1];
   endfunction

   isf_top i_dut (.sys_clk_i(clk), .rst_n_i(rst_n),
      .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
      .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .evt_i(evt), .stat_i(stat), .lock_en_o(lock_en),
      .irq_flags_o(irq_flags));
   isf_host i_host (.sys_clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid),
      .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .bready_o(bready),
      .araddr_o(araddr), .arvalid_o(arvalid), .rready_o(rready), .awready_i(awready),
      .wready_i(wready), .bvalid_i(bvalid), .bresp_i(bresp), .arready_i(arready),
      .rvalid_i(rvalid), .rresp_i(rresp), .rdata_i(rdata));

   // 125 mhz core clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // a hung handshake must not stall the run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         miscompares++;
         results();
      end
   end

   task automatic results();
      if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // read and compare response and low byte together
   task automatic rdc(input logic [11:0] a, input logic [7:0] x, input logic [1:0] rp,
                      input string n);
      logic [31:0] v;
      logic [1:0]  p;
      i_host.rd(a, v, p);
      `CHK(n, {rp, 24'h0, x}, {p, v})
   endtask
   task automatic wrc(input logic [11:0] a, input logic [31:0] v, input logic [1:0] rp);
      logic [1:0] p;
      i_host.wr(a, v, p);
      `CHK("bresp", rp, p)
   endtask
   // wait for the slowest path, the lock change, to land
   task automatic settle();
      repeat (4) @(posedge clk);
   endtask

   // main sequence
   initial begin
      rst_n = 1'b0;
      evt   = '0;
      stat  = '0;
      m     = '0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      d = $urandom(32'heba9);
      rdc(12'h004, 8'h00, 2'h0, "flags");
      rdc(12'h008, 8'h00, 2'h0, "status");
      for (int i = 0; i < 40; i++) begin
         e = 7'($urandom);
         s = $urandom;
         if (i < 7) e = 7'h01 << i;
         if (i == 7) e = 7'h0c;
         m = m | exp_flags(e) | {4'h0, s[6] ^ stat.locked, 3'h0};
         @(posedge clk);
         evt  <= e;
         stat <= s[8:0];
         @(posedge clk);
         evt <= '0;
         settle();
         rdc(12'h004, m, 2'h0, "flags");
         `CHK("irq_flags", m, irq_flags)
         rdc(12'h008, exp_status(s[8:0]), 2'h0, "status");
         d = $urandom;
         stat.any_pin_flag <= d[8];
         wrc(12'h004, d, 2'h0);
         m = m & ~{2'b00, d[5:2], d[1] & ~d[8], d[0]};
         rdc(12'h004, m, 2'h0, "flags clear");
      end
      stat <= '0;
      settle();
      wrc(12'h004, 32'hff, 2'h0);
      wrc(12'h0dc, 32'h1, 2'h0);
      `CHK("lock_en", 1'b1, lock_en)
      stat.locked <= 1'b1;
      settle();
      rdc(12'h004, 8'h00, 2'h0, "sw lock");
      wrc(12'h0dc, 32'h0, 2'h0);
      stat.locked <= 1'b0;
      settle();
      rdc(12'h004, 8'h00, 2'h0, "sw unlock");
      stat.locked <= 1'b1;
      settle();
      rdc(12'h004, 8'h08, 2'h0, "engine lock");
      rdc(12'h008, 8'h20, 2'h0, "locked");
      rdc(12'h0dc, 8'h00, 2'h0, "lock ctl");
      // unmapped places answer slave error, status ignores writes
      rdc(12'h010, 8'h00, 2'h2, "unmapped");
      wrc(12'h010, 32'hff, 2'h2);
      wrc(12'h008, 32'hff, 2'h0);
      rdc(12'h008, 8'h20, 2'h0, "status ro");
      results();
   end
endmodule
